//--- ghs_pkg.sv
// Constants, register map and state of the host signal logic.
// Assumes one 100 MHz clock.
package ghs_pkg;
    // Core clock rate in Hz
    localparam int unsigned CLK_HZ      = 100_000_000;
    // Serial rates in baud
    localparam int unsigned BAUD_MIN    = 4_800;
    localparam int unsigned BAUD_MAX    = 921_600;
    localparam int unsigned BAUD_DEF    = 115_200;
    localparam int unsigned BAUD_RTCM   = 9_600;
    // Times as printed
    localparam int unsigned POR_MS      = 167;
    localparam int unsigned WAKE_MS     = 800;
    localparam int unsigned PPS_HIGH_MS = 100;
    localparam int unsigned FIX_HIGH_MS = 100;
    localparam int unsigned SEC_S       = 1;
    localparam int unsigned HOLD_S      = 10;
    localparam int unsigned START_S     = 2;
    localparam int unsigned RTC_HZ      = 32_768;
    // Most interferers the canceller can track
    localparam logic [3:0]  JAM_MAX     = 4'hC;
    // Derived cycle counts
    localparam int unsigned CYC_PER_MS  = CLK_HZ / 1_000;
    localparam int unsigned POR_CYC     = POR_MS * CYC_PER_MS;
    localparam int unsigned WAKE_CYC    = WAKE_MS * CYC_PER_MS;
    localparam int unsigned PPS_CYC     = PPS_HIGH_MS * CYC_PER_MS;
    localparam int unsigned FIX_CYC     = FIX_HIGH_MS * CYC_PER_MS;
    localparam int unsigned SEC_CYC     = SEC_S * CLK_HZ;
    localparam int unsigned RTCM_DIV    = CLK_HZ / BAUD_RTCM;
    localparam logic [15:0] RTC_HALF    = 16'(CLK_HZ / (2 * RTC_HZ));
    localparam logic [15:0] DIV_MIN     = 16'(CLK_HZ / BAUD_MAX);
    localparam logic [15:0] DIV_MAX     = 16'(CLK_HZ / BAUD_MIN);
    localparam logic [15:0] DIV_DEF     = 16'(CLK_HZ / BAUD_DEF);
    localparam logic [3:0]  HOLD_SEC    = 4'(HOLD_S);
    localparam logic [3:0]  START_SEC   = 4'(START_S);
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_BAUD    = 8'h04;
    localparam logic [7:0]  REG_TXDATA  = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0C;
    localparam logic [7:0]  REG_RX0     = 8'h10;
    localparam logic [7:0]  REG_RTCM    = 8'h14;
    localparam logic [7:0]  REG_CMD     = 8'h18;
    localparam logic [7:0]  REG_BACKUP  = 8'h1C;
    // Control field positions
    localparam int unsigned CTRL_CANC   = 0;
    localparam int unsigned CTRL_ZDA    = 1;
    localparam int unsigned CTRL_RTC    = 2;
    localparam int unsigned CTRL_JAM    = 4;
    // Command codes written to the command register
    localparam logic [31:0] CMD_FACTORY = 32'h0000_00A5;
    localparam logic [31:0] CMD_SLEEP   = 32'h0000_005A;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ghs_bus_t;

    // Serial receiver state
    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [3:0]  bitn;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic        valid;
    } ghs_rx_t;

    // Serial transmitter state
    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [3:0]  bitn;
        logic [9:0]  shift;
    } ghs_tx_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] por_cnt;
        logic        por_done;
        logic        host_uart;
        logic [31:0] backup;
        ghs_rx_t     rx0;
        ghs_rx_t     rx1;
        ghs_tx_t     tx;
        logic        tx_line;
        logic [15:0] baud;
        logic        canc_en;
        logic [3:0]  jam_slots;
        logic        zda_en;
        logic        rtc_out_en;
        logic [31:0] rdata;
        logic        awake;
        logic [31:0] wake_cnt;
        logic [31:0] sec_cnt;
        logic        aligned;
        logic [3:0]  start_wait;
        logic [3:0]  holdover;
        logic        pps_run;
        logic [31:0] pps_cnt;
        logic        pps_line;
        logic        fix_line;
        logic        zda_pulse;
        logic [15:0] rtc_cnt;
        logic        rtc_line;
    } ghs_state_t;

    // Power-on value of the state
    localparam ghs_state_t ST_RST = '{tx_line: 1'b1, awake: 1'b1,
                                      baud: DIV_DEF, default: '0};
endpackage : ghs_pkg

//--- ghs_host_signal.sv
// Host signal logic: serial ports, reset, wake, fix and second
// pulses, clock pin.
// Assumes pin inputs synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Host reprograms serial rate within limits
// - Power-up serial rate 115200, text sentences
// - Primary receive input pulled up, idles high
// - Secondary port takes corrections at 9600
// - Floating port-select pins choose serial host
// - Active-low external reset holds working state reset
// - External reset clears working, keeps backup
// - Only factory command or power-on reset clears backup memory
// - Wake needs high level over 800 ms
// - Canceller off after reset, up to 12
// - Second pulse 100 ms high, second-aligned
// - Second pulse waits for aligned first fix
// - Second pulse freewheels 10 s after loss
// - Time sentence request right after pulse
// - Active output high while module active
// - Fix indicator 0.1 s pulse each second of a fix
// - Clock pin input by default, 32768 Hz option
// - Pin direction follows its current function
// - Power-up reset held 167 ms then released
module ghs_host_signal #(
    parameter int unsigned POR_CYC  = ghs_pkg::POR_CYC,
    parameter int unsigned WAKE_CYC = ghs_pkg::WAKE_CYC,
    parameter int unsigned SEC_CYC  = ghs_pkg::SEC_CYC,
    parameter int unsigned PPS_CYC  = ghs_pkg::PPS_CYC,
    parameter int unsigned FIX_CYC  = ghs_pkg::FIX_CYC,
    parameter int unsigned RTCM_DIV = ghs_pkg::RTCM_DIV
) (
    input  wire logic             clk_in,          // Core clock
    input  wire logic             reset_in,        // Power-on reset
    input  wire logic             ext_reset_n_in,  // External reset
    input  wire ghs_pkg::ghs_bus_t bus_in,         // Register request
    output var  logic [31:0]      rdata_out,       // Read data
    input  wire logic             host_sel_a_in,   // Port select pin
    input  wire logic             host_sel_b_in,   // Port select pin
    output var  logic             host_uart_out,   // Serial host chosen
    input  wire logic             rx0_in,          // Primary receive
    output var  logic             rx0_pull_up_out, // Receive pull-up
    output var  logic             tx0_out,         // Primary transmit
    input  wire logic             rx1_in,          // Correction input
    output var  logic             rtcm_valid_out,  // Correction byte
    output var  logic [7:0]       rtcm_data_out,   // Correction data
    input  wire logic             force_wake_in,   // Forced wake
    input  wire logic             standby_ctrl_in, // Unsupported input
    input  wire logic             fix_valid_in,    // Navigation fix
    input  wire logic             utc_second_in,   // Whole-second mark
    output var  logic             active_out,      // Module active
    output var  logic             pps_out,         // Second pulse
    output var  logic             pps_oe_out,      // Second pulse drive
    output var  logic             fix_indicator_out, // Fix indicator
    output var  logic             fix_indicator_oe_out, // Its drive
    output var  logic             zda_due_out,     // Time sentence due
    output var  logic             canceller_en_out, // Canceller on
    output var  logic [3:0]       canceller_slots_out, // Interferers
    input  wire logic             rtc_clk_wake_pin_in,  // Pin level
    output var  logic             rtc_clk_wake_pin_out, // Pin drive
    output var  logic             rtc_clk_wake_pin_oe_out // Pin enable
);

    ghs_pkg::ghs_state_t st;       // Registered state
    ghs_pkg::ghs_state_t next_st;  // Next state
    ghs_pkg::ghs_state_t keep_st;  // Kept across internal reset
    logic                int_rst;  // Internal reset active
    logic                tick;     // Whole second boundary
    logic [15:0]         wdiv;     // Written rate divisor

    // One receiver step: start, eight data bits, stop
    function automatic ghs_pkg::ghs_rx_t rx_step(
        input ghs_pkg::ghs_rx_t r,
        input logic             pin,
        input logic [15:0]      div
    );
        ghs_pkg::ghs_rx_t q;
        q = r;
        if (!r.busy) begin
            // Low level starts a frame
            if (!pin) begin
                q.busy = 1'b1;
                q.cnt  = div >> 1;
                q.bitn = 4'h0;
            end
        end else if (r.cnt != 16'h0000) begin
            q.cnt = r.cnt - 16'h0001;
        end else begin
            q.cnt = div - 16'h0001;
            if (r.bitn == 4'h0) begin
                // Start bit high again is a glitch
                q.busy = !pin;
                q.bitn = 4'h1;
            end else if (r.bitn < 4'h9) begin
                q.shift = {pin, r.shift[7:1]};
                q.bitn  = r.bitn + 4'h1;
            end else begin
                // Good stop bit keeps the byte
                q.busy = 1'b0;
                if (pin) begin
                    q.data  = r.shift;
                    q.valid = 1'b1;
                end
            end
        end
        return q;
    endfunction : rx_step

    // Internal reset: power-up or external
    assign int_rst = !ext_reset_n_in || !st.por_done;
    // Second: mark during a fix, or free run
    assign tick = (utc_second_in && fix_valid_in) ||
                  (st.sec_cnt == SEC_CYC - 1);
    // Rate divisor clamped to range
    assign wdiv = (bus_in.wdata[15:0] < ghs_pkg::DIV_MIN) ?
                  ghs_pkg::DIV_MIN :
                  (bus_in.wdata[15:0] > ghs_pkg::DIV_MAX) ?
                  ghs_pkg::DIV_MAX : bus_in.wdata[15:0];

    // Next state of the whole block
    always_comb begin
        next_st = st;
        keep_st = st;
        next_st.zda_pulse = 1'b0;
        // Power-up reset interval
        if (!st.por_done) begin
            next_st.por_cnt = st.por_cnt + 32'h0000_0001;
            if (st.por_cnt == POR_CYC - 1) begin
                next_st.por_done = 1'b1;
                // Straps caught at release
                next_st.host_uart = host_sel_a_in && host_sel_b_in;
            end
        end
        if (int_rst) begin
            // Working state lost, backup kept
            keep_st = next_st;
            next_st = ghs_pkg::ST_RST;
            next_st.por_cnt   = keep_st.por_cnt;
            next_st.por_done  = keep_st.por_done;
            next_st.host_uart = keep_st.host_uart;
            next_st.backup    = keep_st.backup;
        end else begin
            // Read data stands one cycle
            next_st.rdata = 32'h0000_0000;
            // Primary receiver, serial host only
            if (bus_in.rd && bus_in.addr == ghs_pkg::REG_RX0) begin
                next_st.rx0.valid = 1'b0;
            end
            if (st.host_uart) begin
                next_st.rx0 = rx_step(next_st.rx0, rx0_in, st.baud);
            end
            // Correction receiver at its fixed rate
            if (bus_in.rd && bus_in.addr == ghs_pkg::REG_RTCM) begin
                next_st.rx1.valid = 1'b0;
            end
            next_st.rx1 = rx_step(next_st.rx1, rx1_in,
                                  16'(RTCM_DIV));
            // Transmitter shifts out start, data, stop
            if (st.tx.busy) begin
                if (st.tx.cnt != 16'h0000) begin
                    next_st.tx.cnt = st.tx.cnt - 16'h0001;
                end else if (st.tx.bitn == 4'h9) begin
                    next_st.tx.busy = 1'b0;
                    next_st.tx_line = 1'b1;
                end else begin
                    next_st.tx.cnt   = st.baud - 16'h0001;
                    next_st.tx.bitn  = st.tx.bitn + 4'h1;
                    next_st.tx.shift = {1'b1, st.tx.shift[9:1]};
                    next_st.tx_line  = st.tx.shift[1];
                end
            end
            // Register writes
            if (bus_in.wr) begin
                unique case (bus_in.addr)
                    ghs_pkg::REG_CTRL: begin
                        next_st.canc_en =
                            bus_in.wdata[ghs_pkg::CTRL_CANC];
                        next_st.zda_en = bus_in.wdata[ghs_pkg::CTRL_ZDA];
                        next_st.rtc_out_en =
                            bus_in.wdata[ghs_pkg::CTRL_RTC];
                        next_st.jam_slots =
                            (bus_in.wdata[ghs_pkg::CTRL_JAM +: 4] >
                             ghs_pkg::JAM_MAX) ? ghs_pkg::JAM_MAX :
                            bus_in.wdata[ghs_pkg::CTRL_JAM +: 4];
                    end
                    ghs_pkg::REG_BAUD: begin
                        next_st.baud = wdiv;
                    end
                    ghs_pkg::REG_TXDATA: begin
                        // Ignored while busy or not serial host
                        if (!st.tx.busy && st.host_uart) begin
                            next_st.tx.busy  = 1'b1;
                            next_st.tx.cnt   = st.baud - 16'h0001;
                            next_st.tx.bitn  = 4'h0;
                            next_st.tx.shift = {1'b1,
                                                bus_in.wdata[7:0], 1'b0};
                            next_st.tx_line  = 1'b0;
                        end
                    end
                    ghs_pkg::REG_CMD: begin
                        if (bus_in.wdata == ghs_pkg::CMD_FACTORY) begin
                            next_st.backup = 32'h0000_0000;
                        end else if (bus_in.wdata == ghs_pkg::CMD_SLEEP) begin
                            next_st.awake = 1'b0;
                        end
                    end
                    ghs_pkg::REG_BACKUP: begin
                        next_st.backup = bus_in.wdata;
                    end
                    default: begin
                        // Read-only and unmapped: ignored
                    end
                endcase
            end
            // Register reads
            if (bus_in.rd) begin
                unique case (bus_in.addr)
                    ghs_pkg::REG_CTRL: begin
                        next_st.rdata[ghs_pkg::CTRL_CANC] = st.canc_en;
                        next_st.rdata[ghs_pkg::CTRL_ZDA]  = st.zda_en;
                        next_st.rdata[ghs_pkg::CTRL_RTC]  = st.rtc_out_en;
                        next_st.rdata[ghs_pkg::CTRL_JAM +: 4] = st.jam_slots;
                    end
                    ghs_pkg::REG_BAUD: begin
                        next_st.rdata[15:0] = st.baud;
                    end
                    ghs_pkg::REG_STATUS: begin
                        next_st.rdata[8:0] = {standby_ctrl_in,
                                              rtc_clk_wake_pin_in,
                                              st.host_uart, st.rx1.valid,
                                              st.rx0.valid, st.tx.busy,
                                              st.awake, st.pps_run,
                                              fix_valid_in};
                    end
                    ghs_pkg::REG_RX0: begin
                        next_st.rdata[7:0] = st.rx0.data;
                    end
                    ghs_pkg::REG_RTCM: begin
                        next_st.rdata[7:0] = st.rx1.data;
                    end
                    ghs_pkg::REG_BACKUP: begin
                        next_st.rdata = st.backup;
                    end
                    default: begin
                        // Unmapped offsets read zero
                    end
                endcase
            end
            // Wake needs an unbroken high
            if (!force_wake_in) begin
                next_st.wake_cnt = 32'h0000_0000;
            end else if (st.wake_cnt < WAKE_CYC) begin
                next_st.wake_cnt = st.wake_cnt + 32'h0000_0001;
            end else begin
                next_st.awake = 1'b1;
            end
            // Second counter, resynchronised by the mark
            next_st.sec_cnt = tick ? 32'h0000_0000 :
                              st.sec_cnt + 32'h0000_0001;
            // Fix indicator: short high each second of a fix
            next_st.fix_line = fix_valid_in &&
                               (next_st.sec_cnt < FIX_CYC);
            // Second pulse arming, start delay and holdover
            if (tick) begin
                if (fix_valid_in) begin
                    next_st.holdover = ghs_pkg::HOLD_SEC;
                    if (!st.aligned) begin
                        next_st.aligned    = 1'b1;
                        next_st.start_wait = ghs_pkg::START_SEC;
                    end else if (st.start_wait != 4'h0) begin
                        next_st.start_wait = st.start_wait - 4'h1;
                    end else begin
                        next_st.pps_run = 1'b1;
                    end
                end else if (st.holdover > 4'h1) begin
                    next_st.holdover = st.holdover - 4'h1;
                end else begin
                    // Holdover spent: stop, wait for fix
                    next_st.holdover = 4'h0;
                    next_st.pps_run  = 1'b0;
                    next_st.aligned  = 1'b0;
                end
            end
            // Fixed-length pulse on the second
            if (tick && next_st.pps_run) begin
                next_st.pps_line = 1'b1;
                next_st.pps_cnt  = PPS_CYC - 1;
            end else if (st.pps_cnt != 32'h0000_0000) begin
                next_st.pps_cnt = st.pps_cnt - 32'h0000_0001;
            end else if (st.pps_line) begin
                next_st.pps_line  = 1'b0;
                // Time sentence due as the pulse ends
                next_st.zda_pulse = st.zda_en;
            end
            // Clock divider, idle while the pin is an input
            if (!st.rtc_out_en || st.rtc_cnt == 16'h0000) begin
                next_st.rtc_cnt  = ghs_pkg::RTC_HALF - 16'h0001;
                next_st.rtc_line = st.rtc_out_en && !st.rtc_line;
            end else begin
                next_st.rtc_cnt = st.rtc_cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st <= ghs_pkg::ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs from the state, active_out also gated by internal reset
    assign rdata_out            = st.rdata;
    assign host_uart_out        = st.host_uart;
    assign rx0_pull_up_out      = 1'b1;
    assign tx0_out              = st.tx_line;
    assign rtcm_valid_out       = st.rx1.valid;
    assign rtcm_data_out        = st.rx1.data;
    assign active_out           = st.awake && !int_rst;
    assign pps_out              = st.pps_line;
    assign pps_oe_out           = st.awake;
    assign fix_indicator_out    = st.fix_line;
    assign fix_indicator_oe_out = st.awake;
    assign zda_due_out          = st.zda_pulse;
    assign canceller_en_out     = st.canc_en;
    assign canceller_slots_out  = st.canc_en ? st.jam_slots : 4'h0;
    assign rtc_clk_wake_pin_out = st.rtc_line;
    assign rtc_clk_wake_pin_oe_out = st.rtc_out_en;

endmodule : ghs_host_signal

`default_nettype wire

//--- ghs_unused_placeholder_never.sv
// No logic.
`default_nettype none
`default_nettype wire

//--- ghs_props.sv
// Port checks of the host signal block.
// Assumes a bind onto ghs_host_signal.
`timescale 1ns/100ps
`default_nettype none
module ghs_props #(parameter int unsigned PPS_CYC = 20) (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       ext_reset_n_in,
    input wire logic       tx0_out,
    input wire logic       rx0_pull_up_out,
    input wire logic       fix_valid_in,
    input wire logic       active_out,
    input wire logic       pps_out,
    input wire logic       fix_indicator_out,
    input wire logic       zda_due_out,
    input wire logic       canceller_en_out,
    input wire logic [3:0] canceller_slots_out,
    input wire logic       rtc_clk_wake_pin_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic [31:0] high_cnt;
    // Counts high samples of the second pulse
    always_ff @(posedge clk_in) begin
        high_cnt <= pps_out ? high_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
    pull_up_a: assert property (rx0_pull_up_out)
        else $error("pull-up off");
    pps_width_a: assert property (
        $fell(pps_out) && ext_reset_n_in |-> high_cnt == PPS_CYC)
        else $error("bad pulse width");
    fix_low_a: assert property (
        !fix_valid_in ##1 !fix_valid_in |-> !fix_indicator_out)
        else $error("fix high without fix");
    fix_cause_a: assert property (
        $rose(fix_indicator_out) |-> $past(fix_valid_in))
        else $error("fix rose without fix");
    ext_hold_a: assert property (
        !ext_reset_n_in [*2] |-> !active_out)
        else $error("active in external reset");
    slots_cap_a: assert property (
        canceller_slots_out <= (canceller_en_out ? ghs_pkg::JAM_MAX : 4'h0))
        else $error("slots out of range");
    zda_after_a: assert property (
        zda_due_out |-> !pps_out && ($past(pps_out) || $past(pps_out, 2)))
        else $error("time request not after pulse");
    reset_vals_a: assert property (
        $fell(reset_in) |-> tx0_out && !canceller_en_out
            && !rtc_clk_wake_pin_oe_out)
        else $error("wrong values after reset");
endmodule : ghs_props
bind ghs_host_signal ghs_props #(.PPS_CYC(PPS_CYC)) ghs_props_inst (.*);
`default_nettype wire

//--- ghs_host_uart.sv
// Host serial sender on one receive pin of the block.
// Assumes the bench calls send_byte.
`timescale 1ns/100ps
`default_nettype none
module ghs_host_uart #(parameter int DIV = 16) (
    input  wire logic clk_in,  // Core clock
    output var  logic line_out // Serial line
);
    initial line_out = 1'b1; // Idle high
    // Start, data LSB first, stop at the agreed rate
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            line_out <= f[i];
            repeat (DIV - 1) @(posedge clk_in);
        end
    endtask : send_byte
endmodule : ghs_host_uart
`default_nettype wire

//--- test_gnss_host_signal_logic.sv
// Self-checking bench of the host signal block.
// Assumes shortened counts.
`timescale 1ns/100ps
`default_nettype none
module test_gnss_host_signal_logic;
    logic clk_in, reset_in, ext_reset_n_in, rx0_in, rx1_in, force_wake_in;
    logic fix_valid_in, utc_second_in, rtc_clk_wake_pin_in, standby_ctrl_in;
    logic host_sel_a_in, host_sel_b_in, host_uart_out, rx0_pull_up_out;
    logic tx0_out, rtcm_valid_out, active_out, pps_out, pps_oe_out;
    logic fix_indicator_out, fix_indicator_oe_out, zda_due_out;
    logic canceller_en_out, rtc_clk_wake_pin_out, rtc_clk_wake_pin_oe_out;
    ghs_pkg::ghs_bus_t bus_in;
    logic [31:0] rdata_out;
    logic [7:0] rtcm_data_out;
    logic [3:0] canceller_slots_out;
    logic [9:0] bits;
    int fail_count = 0, num_checks = 0, pps_rises, zda_seen, fix_seen;
    ghs_host_signal #(.POR_CYC(20), .WAKE_CYC(30), .SEC_CYC(200),
        .PPS_CYC(20), .FIX_CYC(20), .RTCM_DIV(16)) ghs_host_signal_inst (.*);
    ghs_host_uart #(.DIV(108)) host0_inst (.clk_in, .line_out(rx0_in));
    ghs_host_uart #(.DIV(16)) host1_inst (.clk_in, .line_out(rx1_in));
    // Clock of 10 ns period
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Counts pulses on the timing outputs
    always @(posedge clk_in) begin
        if ($rose(pps_out)) pps_rises++;
        if ($rose(fix_indicator_out)) fix_seen++;
        if (zda_due_out === 1'b1) zda_seen++;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask : wr
    task automatic rc(input string n, input logic [7:0] a, logic [31:0] e);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        #1 chk(n, rdata_out, e);
    endtask : rc
    task automatic secs(input int n);
        repeat (n) begin
            repeat (199) @(posedge clk_in);
            utc_second_in <= 1'b1;
            @(posedge clk_in);
            utc_second_in <= 1'b0;
        end
    endtask : secs
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Hang guard
    initial begin
        #600_000;
        fail_count++;
        final_report();
    end
    // Test sequence
    initial begin
        {reset_in, ext_reset_n_in, host_sel_a_in, host_sel_b_in} = 4'hF;
        {force_wake_in, fix_valid_in, utc_second_in} = 3'h0;
        {rtc_clk_wake_pin_in, standby_ctrl_in} = 2'h0;
        bus_in = '0;
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("active early", active_out, 0);
        repeat (15) @(posedge clk_in);
        chk("active", active_out, 1);
        chk("host uart", host_uart_out, 1);
        rtc_clk_wake_pin_in <= 1'b1;
        rc("status", ghs_pkg::REG_STATUS, 32'h0000_00C4);
        rc("baud", ghs_pkg::REG_BAUD, 32'(ghs_pkg::DIV_DEF));
        rc("unmapped", 8'h20, 32'h0000_0000);
        $display("test power-up done");
        wr(ghs_pkg::REG_BAUD, 32'h0000_0001);
        rc("baud min", ghs_pkg::REG_BAUD, 32'(ghs_pkg::DIV_MIN));
        wr(ghs_pkg::REG_BAUD, 32'h0000_FFFF);
        rc("baud max", ghs_pkg::REG_BAUD, 32'(ghs_pkg::DIV_MAX));
        wr(ghs_pkg::REG_BAUD, 32'(ghs_pkg::DIV_MIN));
        wr(ghs_pkg::REG_TXDATA, 32'h0000_00A5);
        repeat (54) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            bits[i] = tx0_out;
            repeat (108) @(posedge clk_in);
        end
        chk("tx frame", 32'(bits), 32'h0000_034A);
        host0_inst.send_byte(8'h3C);
        repeat (120) @(posedge clk_in);
        rc("rx0", ghs_pkg::REG_RX0, 32'h0000_003C);
        host1_inst.send_byte(8'h96);
        repeat (20) @(posedge clk_in);
        chk("rtcm", {23'h0, rtcm_valid_out, rtcm_data_out}, 32'h196);
        $display("test serial done");
        wr(ghs_pkg::REG_CTRL, 32'h0000_00F3);
        rc("ctrl", ghs_pkg::REG_CTRL, 32'h0000_00C3);
        chk("slots", {28'h0, canceller_slots_out}, 32'hC);
        wr(ghs_pkg::REG_BACKUP, 32'h1234_5678);
        ext_reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        ext_reset_n_in <= 1'b1;
        rc("backup kept", ghs_pkg::REG_BACKUP, 32'h1234_5678);
        rc("ctrl cleared", ghs_pkg::REG_CTRL, 32'h0000_0000);
        wr(ghs_pkg::REG_CMD, ghs_pkg::CMD_FACTORY);
        rc("backup cleared", ghs_pkg::REG_BACKUP, 32'h0000_0000);
        $display("test reset done");
        wr(ghs_pkg::REG_CTRL, 32'h0000_0002);
        fix_valid_in <= 1'b1;
        secs(3);
        chk("early pulse", pps_rises, 0);
        secs(4);
        chk("pulses", 32'(pps_rises >= 3), 1);
        chk("time req", 32'(zda_seen >= 3), 1);
        chk("fix ind", 32'(fix_seen >= 5), 1);
        fix_valid_in <= 1'b0;
        pps_rises = 0;
        secs(5);
        chk("holdover", 32'(pps_rises >= 3), 1);
        secs(8);
        pps_rises = 0;
        secs(3);
        chk("stopped", pps_rises, 0);
        $display("test timing done");
        wr(ghs_pkg::REG_CMD, ghs_pkg::CMD_SLEEP);
        force_wake_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        force_wake_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("short wake", active_out, 0);
        force_wake_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        chk("wake", active_out, 1);
        wr(ghs_pkg::REG_CTRL, 32'h0000_0004);
        #1 chk("clock pin", rtc_clk_wake_pin_oe_out, 1);
        $display("test wake done");
        host_sel_b_in <= 1'b0;
        reset_in <= 1'b1;
        @(posedge clk_in) reset_in <= 1'b0;
        repeat (25) @(posedge clk_in);
        chk("strap", host_uart_out, 0);
        final_report();
    end
endmodule : test_gnss_host_signal_logic
`default_nettype wire
